// ### verilog/mrc_top.sv
// mode register one and two holding and decode for the device.
// assumes command pins are sampled on the device clock clk; the
// termination pin runs with the strobe clock link_clk and the self
// refresh and preamble levels come from other logic asynchronously.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) bit zero switches loop off/on
// (R2) loop off in self refresh, back after
// (R3) controller waits lock time before reads
// (R4) controller holds clock enable high meanwhile
// (R5) writes need loop only for write termination
// (R6) loop off: controller keeps nominal off
// (R7) loop off: controller sets write termination off
// (R8) bits two,one pick driver impedance
// (R9) nominal, write, park; write applies always
// (R10) park applies when termination pin low
// (R11) commands delayed internally by additive latency
// (R12) read delay is additive plus column delay
// (R13) bit twelve disconnects all outputs
// (R14) set command loads register by selector
// (R15) write crc stretches burst eight to ten
// (R16) write termination field decode
// (R17) leveling mode offers only write termination
// (R18) self refresh temperature range select
// (R19) cas write delay table, preamble dependent
// (R20) write delay sums additive, parity, cas
// (R21) target refresh bank group and bank
// (R22) controller refreshes after max activates
// (R23) nominal termination field decode
// (R24) bit seven enables write leveling
// (R25) registers hold until reloaded or reset
module mrc_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        link_clk,
  input  wire logic        cs_n,
  input  wire logic        act_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  mr_sel,
  input  wire logic [17:0] addr,
  input  wire logic [6:0]  read_column_delay,
  input  wire logic [2:0]  parity_delay,
  input  wire logic [3:0]  park_termination,
  input  wire logic        preamble_two,
  input  wire logic        self_refresh,
  input  wire logic        write_active,
  input  wire logic        odt_pin,
  output logic [17:0] mode_reg_one,
  output logic [17:0] mode_reg_two,
  output logic        loop_enable,
  output logic [1:0]  driver_impedance,
  output logic        output_disable,
  output logic        write_leveling,
  output logic [6:0]  additive_latency,
  output logic [6:0]  read_delay_total,
  output logic [6:0]  write_delay_total,
  output logic [4:0]  cas_write_delay,
  output logic        cwl_invalid,
  output logic [3:0]  nominal_termination,
  output logic [3:0]  write_termination,
  output logic [3:0]  link_termination,
  output logic        write_rtt_needs_loop,
  output logic [4:0]  write_burst_ui,
  output logic [1:0]  self_refresh_temp_range,
  output logic        automatic_range_switching,
  output logic        target_row_refresh,
  output logic [1:0]  trr_bank_group,
  output logic [1:0]  trr_bank
);

  // ************************************************************
  // decode functions
  // ************************************************************
  function automatic logic [3:0] dec_nom(input logic [2:0] c);
    case (c)
      3'h0: dec_nom = mrc_pkg::MRC_RTT_OFF;
      3'h1: dec_nom = mrc_pkg::MRC_RZQ_4;
      3'h2: dec_nom = mrc_pkg::MRC_RZQ_2;
      3'h3: dec_nom = mrc_pkg::MRC_RZQ_6;
      3'h4: dec_nom = mrc_pkg::MRC_RZQ_1;
      3'h5: dec_nom = mrc_pkg::MRC_RZQ_5;
      3'h6: dec_nom = mrc_pkg::MRC_RZQ_3;
      default: dec_nom = mrc_pkg::MRC_RZQ_7;
    endcase
  endfunction : dec_nom

  function automatic logic [3:0] dec_wr(input logic [2:0] c);
    case (c)
      3'h0: dec_wr = mrc_pkg::MRC_RTT_OFF;
      3'h1: dec_wr = mrc_pkg::MRC_RZQ_2;
      3'h2: dec_wr = mrc_pkg::MRC_RZQ_1;
      3'h3: dec_wr = mrc_pkg::MRC_HIZ;
      3'h4: dec_wr = mrc_pkg::MRC_RZQ_3;
      default: dec_wr = mrc_pkg::MRC_RSVD;
    endcase
  endfunction : dec_wr

  function automatic logic [4:0] dec_cwl(input logic [2:0] c);
    case (c)
      3'h0: dec_cwl = 5'h09;
      3'h1: dec_cwl = 5'h0a;
      3'h2: dec_cwl = 5'h0b;
      3'h3: dec_cwl = 5'h0c;
      3'h4: dec_cwl = 5'h0e;
      3'h5: dec_cwl = 5'h10;
      3'h6: dec_cwl = 5'h12;
      default: dec_cwl = 5'h14;
    endcase
  endfunction : dec_cwl

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic sr_s;
  logic pre2_s;

  mrc_sync u_sync_sr (
    .clk   (clk),
    .reset (reset),
    .d     (self_refresh),
    .q     (sr_s)
  );

  mrc_sync u_sync_pre (
    .clk   (clk),
    .reset (reset),
    .d     (preamble_two),
    .q     (pre2_s)
  );

  // ************************************************************
  // mode register set capture
  // ************************************************************
  logic [17:0] one_r;
  logic [17:0] one_nxt;
  logic [17:0] two_r;
  logic [17:0] two_nxt;
  logic        mrs_cmd;

  // set command: chip selected, not activate, ras/cas/we all low
  assign mrs_cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n;

  // load only the selected register, others keep their value
  always_comb begin
    one_nxt = one_r; // [R25]
    two_nxt = two_r; // [R25]
    if (mrs_cmd && mr_sel == mrc_pkg::SEL_ONE) begin
      one_nxt = addr; // [R14]
    end else if (mrs_cmd && mr_sel == mrc_pkg::SEL_TWO) begin
      two_nxt = addr; // [R14]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      one_r <= mrc_pkg::MR_RST;
      two_r <= mrc_pkg::MR_RST;
    end else begin
      one_r <= one_nxt;
      two_r <= two_nxt;
    end
  end

  // ************************************************************
  // derived settings, registered
  // ************************************************************
  logic [6:0] al_val;
  logic [4:0] cwl_val;
  logic [3:0] nom_val;
  logic [3:0] wr_val;

  assign nom_val = dec_nom(one_r[mrc_pkg::M1_NOM_L +: 3]); // [R23]
  assign wr_val  = dec_wr(two_r[mrc_pkg::M2_WR_L +: 3]); // [R16]
  assign cwl_val = dec_cwl(two_r[mrc_pkg::M2_CWL_L +: 3]); // [R19]

  // additive latency; reserved code treated as zero
  always_comb begin
    case (one_r[mrc_pkg::M1_AL_L +: 2])
      mrc_pkg::AL_M1: al_val = read_column_delay - 7'h01; // [R12]
      mrc_pkg::AL_M2: al_val = read_column_delay - 7'h02; // [R12]
      default:        al_val = 7'h00;
    endcase
  end

  logic [6:0]  rl_nxt;
  logic [6:0]  wl_nxt;
  logic [6:0]  al_r;
  logic [6:0]  rl_r;
  logic [6:0]  wl_r;
  logic [4:0]  cwl_r;
  logic        cwl_bad_r;
  logic        cwl_bad_nxt;
  logic        loop_r;
  logic        loop_nxt;
  logic [3:0]  nom_r;
  logic [3:0]  wr_r;
  logic        wneed_r;
  logic        wneed_nxt;
  logic [4:0]  burst_r;
  logic [4:0]  burst_nxt;
  logic        asr_r;
  logic        asr_nxt;

  // whole-cycle sums only; half-cycle latencies cannot be set
  always_comb begin
    rl_nxt = al_val + read_column_delay; // [R12] [R11]
    wl_nxt = al_val + {4'h0, parity_delay} + {2'h0, cwl_val}; // [R20]
    // two-cycle preamble rules out the four lowest codes
    cwl_bad_nxt = pre2_s &&
      (two_r[mrc_pkg::M2_CWL_L +: 3] < mrc_pkg::CWL_PRE2_MIN); // [R19]
    // loop follows bit zero but drops during self refresh
    loop_nxt = one_r[mrc_pkg::M1_DLL] && !sr_s; // [R1] [R2]
    // write termination demands a running loop for writes
    wneed_nxt = (wr_val != mrc_pkg::MRC_RTT_OFF); // [R5]
    burst_nxt = two_r[mrc_pkg::M2_CRC] ? mrc_pkg::BURST_CRC
                                        : mrc_pkg::BURST_NORMAL; // [R15]
    asr_nxt = &two_r[mrc_pkg::M2_SR_L +: 2]; // [R18]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      al_r      <= 7'h00;
      rl_r      <= 7'h00;
      wl_r      <= 7'h00;
      cwl_r     <= 5'h00;
      cwl_bad_r <= 1'b0;
      loop_r    <= 1'b0;
      nom_r     <= 4'h0;
      wr_r      <= 4'h0;
      wneed_r   <= 1'b0;
      burst_r   <= mrc_pkg::BURST_NORMAL;
      asr_r     <= 1'b0;
    end else begin
      al_r      <= al_val;
      rl_r      <= rl_nxt;
      wl_r      <= wl_nxt;
      cwl_r     <= cwl_val;
      cwl_bad_r <= cwl_bad_nxt;
      loop_r    <= loop_nxt;
      nom_r     <= nom_val;
      wr_r      <= wr_val;
      wneed_r   <= wneed_nxt;
      burst_r   <= burst_nxt;
      asr_r     <= asr_nxt;
    end
  end

  // ************************************************************
  // link-side termination select
  // ************************************************************
  // the settings word crosses as a bundle of two-flop synchronisers; a
  // word is taken only once two samples agree, so a torn capture is lost
  logic [12:0] cfg_meta_r;
  logic [12:0] cfg_s_r;
  logic [12:0] cfg_chk_r;
  logic [12:0] cfg_r;
  logic [12:0] cfg_nxt;
  logic [1:0]  lk_ctl_meta_r;
  logic [1:0]  lk_ctl_s_r;
  logic [3:0]  lrtt_r;
  logic [3:0]  lrtt_nxt;
  logic        lk_rst_meta_r;
  logic        lk_rst_r;

  // word {leveling, write, nominal, park}; park, nominal or write at pin
  always_comb begin
    cfg_nxt  = (cfg_s_r == cfg_chk_r) ? cfg_s_r : cfg_r;
    lrtt_nxt = cfg_r[7:4]; // [R9]
    if (cfg_r[12]) begin
      lrtt_nxt = cfg_r[11:8]; // [R17]
    end else if (lk_ctl_s_r[0] && cfg_r[11:8] != mrc_pkg::MRC_RTT_OFF) begin
      lrtt_nxt = cfg_r[11:8]; // [R9]
    end else if (!lk_ctl_s_r[1]) begin
      lrtt_nxt = cfg_r[3:0]; // [R10]
    end
  end

  // reset release is resynchronised into the link domain
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lk_rst_meta_r <= 1'b1;
      lk_rst_r      <= 1'b1;
    end else begin
      lk_rst_meta_r <= 1'b0;
      lk_rst_r      <= lk_rst_meta_r;
    end
  end

  always_ff @(posedge link_clk or posedge lk_rst_r) begin
    if (lk_rst_r) begin
      cfg_meta_r    <= 13'h0000;
      cfg_s_r       <= 13'h0000;
      cfg_chk_r     <= 13'h0000;
      cfg_r         <= 13'h0000;
      lk_ctl_meta_r <= 2'h0;
      lk_ctl_s_r    <= 2'h0;
      lrtt_r        <= 4'h0;
    end else begin
      cfg_meta_r    <= {one_r[mrc_pkg::M1_WLV], wr_r, nom_r, park_termination};
      cfg_s_r       <= cfg_meta_r;
      cfg_chk_r     <= cfg_s_r;
      cfg_r         <= cfg_nxt;
      lk_ctl_meta_r <= {odt_pin, write_active};
      lk_ctl_s_r    <= lk_ctl_meta_r;
      lrtt_r        <= lrtt_nxt;
    end
  end

  // ************************************************************
  // outputs, all straight from flops
  // ************************************************************
  assign mode_reg_one        = one_r;
  assign mode_reg_two        = two_r;
  assign loop_enable         = loop_r;
  assign driver_impedance    = one_r[mrc_pkg::M1_ODI_L +: 2]; // [R8]
  assign output_disable      = one_r[mrc_pkg::M1_OUTPUT_DISABLE]; // [R13]
  assign write_leveling      = one_r[mrc_pkg::M1_WLV]; // [R24]
  assign additive_latency    = al_r;
  assign read_delay_total    = rl_r;
  assign write_delay_total   = wl_r;
  assign cas_write_delay     = cwl_r;
  assign cwl_invalid         = cwl_bad_r;
  assign nominal_termination = nom_r;
  assign write_termination   = wr_r;
  assign link_termination    = lrtt_r;
  assign write_rtt_needs_loop = wneed_r;
  assign write_burst_ui      = burst_r;
  assign self_refresh_temp_range = two_r[mrc_pkg::M2_SR_L +: 2]; // [R18]
  assign automatic_range_switching = asr_r; // [R18]
  assign target_row_refresh  = two_r[mrc_pkg::M2_TRR]; // [R21]
  assign trr_bank_group = {two_r[mrc_pkg::M2_TG_HI],
                           two_r[mrc_pkg::M2_TG_LO]}; // [R21]
  assign trr_bank       = two_r[mrc_pkg::M2_TB_L +: 2]; // [R21]

endmodule : mrc_top
`default_nettype wire

// ### verilog/mrc_pkg.sv
// mode register one/two configuration constants: field positions,
// selector codes, termination and latency codes.
// assumes one device clock domain for the command pins; the
// termination pin and self refresh state arrive from other domains.
package mrc_pkg;

  // ************************************************************
  // register layout
  // ************************************************************
  localparam int MR_W          = 18;
  localparam int SEL_W         = 3;
  localparam logic [2:0] SEL_ONE = 3'h1;
  localparam logic [2:0] SEL_TWO = 3'h2;
  localparam logic [2:0] SEL_DNU = 3'h7;
  localparam logic [17:0] MR_RST = 18'h00000;

  // mode register one fields
  localparam int M1_DLL   = 0;
  localparam int M1_ODI_L = 1;
  localparam int M1_AL_L  = 3;
  localparam int M1_WLV   = 7;
  localparam int M1_NOM_L = 8;
  localparam int M1_OUTPUT_DISABLE  = 12;

  // mode register two fields
  localparam int M2_TB_L  = 0;
  localparam int M2_TG_LO = 2;
  localparam int M2_CWL_L = 3;
  localparam int M2_SR_L  = 6;
  localparam int M2_TG_HI = 8;
  localparam int M2_WR_L  = 9;
  localparam int M2_CRC   = 12;
  localparam int M2_TRR   = 13;

  // ************************************************************
  // termination codes, output shared encoding
  // ************************************************************
  typedef enum logic [3:0] {
    MRC_RTT_OFF  = 4'h0,
    MRC_RZQ_1    = 4'h1,
    MRC_RZQ_2    = 4'h2,
    MRC_RZQ_3    = 4'h3,
    MRC_RZQ_4    = 4'h4,
    MRC_RZQ_5    = 4'h5,
    MRC_RZQ_6    = 4'h6,
    MRC_RZQ_7    = 4'h7,
    MRC_HIZ      = 4'h8,
    MRC_RSVD     = 4'hf
  } mrc_rtt_t;

  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_M1   = 2'h1;
  localparam logic [1:0] AL_M2   = 2'h2;
  localparam logic [4:0] BURST_NORMAL = 5'h08;
  localparam logic [4:0] BURST_CRC    = 5'h0a;
  localparam logic [2:0] CWL_PRE2_MIN = 3'h4;
  localparam int LAT_W = 7;

endpackage : mrc_pkg

// ### verilog/mrc_sync.sv
// two-flop level synchroniser for signals entering the device clock.
// assumes the input is a slow level from another domain.
`timescale 1ns/1ps
`default_nettype none
module mrc_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  // first stage feeds only the second
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : mrc_sync
`default_nettype wire

// ### tb/mrc_props.sv
// checker for mrc_top: register loads, holding and derived values.
// assumes it is bound to mrc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mrc_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic        act_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  mr_sel,
  input wire logic [17:0] addr,
  input wire logic [6:0]  read_column_delay,
  input wire logic [2:0]  parity_delay,
  input wire logic        self_refresh,
  input wire logic [17:0] mode_reg_one,
  input wire logic [17:0] mode_reg_two,
  input wire logic        loop_enable,
  input wire logic [6:0]  additive_latency,
  input wire logic [6:0]  read_delay_total,
  input wire logic [6:0]  write_delay_total,
  input wire logic [4:0]  cas_write_delay,
  input wire logic [4:0]  write_burst_ui,
  input wire logic [1:0]  trr_bank_group,
  input wire logic [1:0]  trr_bank
);
  // **********
  // assertions
  // **********
  logic cmd;
  // set command as seen on the pins
  assign cmd = !cs_n && act_n && !ras_n && !cas_n && !we_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_load_one: assert property (
    cmd && mr_sel == mrc_pkg::SEL_ONE |=> mode_reg_one == $past(addr))
    else $error("register one load wrong");
  a_load_two: assert property (
    cmd && mr_sel == mrc_pkg::SEL_TWO |=> mode_reg_two == $past(addr))
    else $error("register two load wrong");
  a_hold_one: assert property (
    !(cmd && mr_sel == mrc_pkg::SEL_ONE) |=> $stable(mode_reg_one))
    else $error("register one changed without a load");
  // settle time of three cycles covers the derive stage
  a_loop_off: assert property (
    (!mode_reg_one[0]) [*3] |-> !loop_enable)
    else $error("loop on while bit zero clear");
  a_refresh_off: assert property (
    self_refresh [*6] |-> !loop_enable)
    else $error("loop on during self refresh");
  a_burst_len: assert property (
    $stable(mode_reg_two) [*3] |->
      write_burst_ui == (mode_reg_two[12] ? 5'h0a : 5'h08))
    else $error("write burst length wrong");
  a_read_sum: assert property (
    ($stable(additive_latency) && $stable(read_column_delay)) [*4] |->
      read_delay_total == 7'(additive_latency + read_column_delay))
    else $error("read delay sum wrong");
  a_write_sum: assert property (
    ($stable(additive_latency) && $stable(cas_write_delay)
      && $stable(parity_delay)) [*4] |-> write_delay_total ==
      7'(additive_latency + parity_delay + cas_write_delay))
    else $error("write delay sum wrong");
  a_trr_fields: assert property (
    cmd && mr_sel == mrc_pkg::SEL_TWO |=> {trr_bank_group, trr_bank} ==
      {$past(addr[8]), $past(addr[2]), $past(addr[1:0])})
    else $error("target refresh fields wrong");
endmodule : mrc_props
`default_nettype wire

// ### tb/mrc_ctrl_model.sv
// controller model: drives set commands on the command pins.
// assumes tasks are called from one bench process at a time.
`timescale 1ns/1ps
`default_nettype none
module mrc_ctrl_model (
  input  wire logic        clk,
  output logic        cs_n,
  output logic        act_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  mr_sel,
  output logic [17:0] addr
);
  // **********
  // command tasks
  // **********
  // only set commands and we_hi look-alikes are issued: no read or synchronous termination
  // command can fall in a lock wait clock enable is not modelled
  // and counts as held high no activates, so no refresh debt
  // deselected at start; act_n stays high for set commands
  initial begin
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
    mr_sel = 3'h0;
    addr = 18'h00000;
  end
  // one command per call, held over the next rising edge; calls may
  // follow each other every cycle; we_hi makes a look-alike
  task automatic set_cmd(input logic [2:0] sel, input logic [17:0] d,
                         input logic we_hi);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = {3'h0, we_hi};
    mr_sel = sel;
    addr = d;
  endtask : set_cmd
  // deselected bus must not keep showing the last value
  task automatic idle();
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    mr_sel = ~mr_sel;
    addr = ~addr;
  endtask : idle
endmodule : mrc_ctrl_model
`default_nettype wire

// ### tb/tb_top.sv
// bench for mrc_top: loads, field decode, self refresh, termination.
// assumes the controller model owns the command pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // **********
  // signals
  // **********
  logic        clk, reset, link_clk, cs_n, act_n, ras_n, cas_n, we_n;
  logic [2:0]  mr_sel, parity_delay, k;
  logic [17:0] addr, mode_reg_one, mode_reg_two, a1, a2;
  logic [6:0]  read_column_delay, additive_latency, al;
  logic [6:0]  read_delay_total, write_delay_total;
  logic [3:0]  park_termination, nominal_termination;
  logic [3:0]  write_termination, link_termination;
  logic        preamble_two, self_refresh, write_active, odt_pin;
  logic        loop_enable, output_disable, write_leveling, cwl_invalid;
  logic        write_rtt_needs_loop, automatic_range_switching;
  logic        target_row_refresh;
  logic [1:0]  driver_impedance, self_refresh_temp_range;
  logic [1:0]  trr_bank_group, trr_bank;
  logic [4:0]  cas_write_delay, write_burst_ui;
  logic [4:0]  nom_t [8] = '{5'h0, 5'h4, 5'h2, 5'h6, 5'h1, 5'h5, 5'h3, 5'h7};
  logic [4:0]  wr_t [8] = '{5'h0, 5'h2, 5'h1, 5'h8, 5'h3, 5'hf, 5'hf, 5'hf};
  logic [4:0]  cw_t [8] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10,
                            5'h12, 5'h14};
  int          n_errors = 0, checks = 0;

  mrc_top i_mrc_top (.clk, .reset, .link_clk, .cs_n, .act_n, .ras_n,
    .cas_n, .we_n, .mr_sel, .addr, .read_column_delay, .parity_delay,
    .park_termination, .preamble_two, .self_refresh, .write_active,
    .odt_pin, .mode_reg_one, .mode_reg_two, .loop_enable,
    .driver_impedance, .output_disable, .write_leveling,
    .additive_latency, .read_delay_total, .write_delay_total,
    .cas_write_delay, .cwl_invalid, .nominal_termination,
    .write_termination, .link_termination, .write_rtt_needs_loop,
    .write_burst_ui, .self_refresh_temp_range,
    .automatic_range_switching, .target_row_refresh, .trr_bank_group,
    .trr_bank);
  mrc_ctrl_model i_mrc_ctrl_model (.clk, .cs_n, .act_n, .ras_n, .cas_n,
    .we_n, .mr_sel, .addr);

  // clocks: link clock offset so its edges never meet the sample edge
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // **********
  // tasks
  // **********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // watchdog: tests need about 160 cycles, allow 10000
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  // **********
  // tests
  // **********
  initial begin
    reset = 1'b1;
    read_column_delay = 7'h14;
    parity_delay = 3'h3;
    park_termination = 4'h5;
    {preamble_two, self_refresh, write_active, odt_pin} = 4'h1;
    cyc(8);
    chk(mode_reg_one, 18'h00000);
    chk(write_burst_ui, 5'h08);
    reset = 1'b0;
    // each field code; code 0 clears bit 0 and both terminations
    for (int c = 0; c < 8; c++) begin
      k = c[2:0];
      preamble_two = k[0];
      a1 = {5'h00, k[0], 1'b0, k, 3'h0, k[1:0], k[1:0], k != 3'h0};
      a2 = {4'h0, k[0], k[0], k, k[2], k[1:0], k, k[1], k[1:0]};
      al = (k[1:0] == 2'h1) ? 7'h13 : (k[1:0] == 2'h2) ? 7'h12 : 7'h00;
      i_mrc_ctrl_model.set_cmd(3'h1, a1, 1'b0);
      i_mrc_ctrl_model.set_cmd(3'h2, a2, 1'b0);
      i_mrc_ctrl_model.idle();
      cyc(6);
      chk(mode_reg_one, a1);
      chk(mode_reg_two, a2);
      chk(loop_enable, k != 3'h0);
      chk(driver_impedance, k[1:0]);
      chk(output_disable, k[0]);
      chk(nominal_termination, nom_t[k]);
      chk(write_termination, wr_t[k]);
      chk(write_rtt_needs_loop, wr_t[k] != 5'h0);
      chk(additive_latency, al);
      chk(read_delay_total, al + 7'h14);
      chk(cas_write_delay, cw_t[k]);
      chk(cwl_invalid, k[0] && k < 3'h4);
      chk(write_delay_total, al + 7'h03 + {2'h0, cw_t[k]});
      chk(write_burst_ui, k[0] ? 5'h0a : 5'h08);
      chk(self_refresh_temp_range, k[1:0]);
      chk(automatic_range_switching, k[1:0] == 2'h3);
      chk(target_row_refresh, k[0]);
      chk({trr_bank_group, trr_bank}, {k[2], k[1], k[1:0]});
    end
    $display("test field decode done");
    // unused selectors and a look-alike command leave both alone
    i_mrc_ctrl_model.set_cmd(3'h7, 18'h3ffff, 1'b0);
    i_mrc_ctrl_model.set_cmd(3'h0, 18'h3ffff, 1'b0);
    i_mrc_ctrl_model.set_cmd(3'h1, 18'h3ffff, 1'b1);
    i_mrc_ctrl_model.idle();
    cyc(4);
    chk(mode_reg_one, a1);
    chk(mode_reg_two, a2);
    $display("test ignored selectors done");
    self_refresh = 1'b1;
    cyc(8);
    chk(loop_enable, 1'b0);
    self_refresh = 1'b0;
    cyc(8);
    chk(loop_enable, 1'b1);
    $display("test self refresh done");
    // nominal 4, write 2, park 5: walk the termination choices
    i_mrc_ctrl_model.set_cmd(3'h1, 18'h00101, 1'b0);
    i_mrc_ctrl_model.set_cmd(3'h2, 18'h00200, 1'b0);
    i_mrc_ctrl_model.idle();
    cyc(12);
    chk(link_termination, 4'h4);
    odt_pin = 1'b0;
    cyc(12);
    chk(link_termination, 4'h5);
    write_active = 1'b1;
    cyc(12);
    chk(link_termination, 4'h2);
    write_active = 1'b0;
    i_mrc_ctrl_model.set_cmd(3'h1, 18'h00181, 1'b0);
    i_mrc_ctrl_model.idle();
    cyc(12);
    chk(write_leveling, 1'b1);
    chk(link_termination, 4'h2);
    $display("test termination done");
    conclude();
  end
endmodule : tb_top

bind mrc_top mrc_props i_mrc_props (.clk, .reset, .cs_n, .act_n, .ras_n,
  .cas_n, .we_n, .mr_sel, .addr, .read_column_delay, .parity_delay,
  .self_refresh, .mode_reg_one, .mode_reg_two, .loop_enable,
  .additive_latency, .read_delay_total, .write_delay_total,
  .cas_write_delay, .write_burst_ui, .trr_bank_group, .trr_bank);
`default_nettype wire
